//--- core/smsp_pkg.sv
package smsp_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] SMSP_OFS_MODE_CTL = 8'h00;
   localparam logic [7:0] SMSP_OFS_DATA = 8'h04;
   localparam logic [7:0] SMSP_OFS_PORT_CTL = 8'h08;
   localparam logic [7:0] SMSP_OFS_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] SMSP_OFS_IRQ_MASK = 8'h10;

   // Values after reset
   localparam logic [7:0] SMSP_RST_MODE_CTL = 8'he0;
   localparam logic [7:0] SMSP_RST_DATA = 8'h00;
   localparam logic [7:0] SMSP_RST_PORT_CTL = 8'h00;
   localparam logic [1:0] SMSP_RST_IRQ = 2'h0;

   // Field positions in serial_mode_control
   localparam int SMSP_ROLE_MSB = 7;
   localparam int SMSP_ROLE_LSB = 5;
   localparam int SMSP_ENABLE_BIT = 1;
   localparam logic [7:0] SMSP_MODE_CTL_RW = 8'hfe;

   // Field positions in serial_port_control
   localparam int SMSP_POL_BIT = 5;
   localparam int SMSP_EDGE_BIT = 4;
   localparam int SMSP_ORDER_BIT = 3;
   localparam int SMSP_SEL_EN_BIT = 2;
   localparam int SMSP_WRITE_COLLISION_FLAG_BIT = 1;
   localparam int SMSP_TRF_BIT = 0;

   // Field positions in the interrupt status and mask registers
   localparam int SMSP_IRQ_DONE_BIT = 0;
   localparam int SMSP_IRQ_WRITE_COLLISION_FLAG_BIT = 1;

   // Role codes
   localparam logic [2:0] SMSP_ROLE_DIV4 = 3'h0;
   localparam logic [2:0] SMSP_ROLE_DIV16 = 3'h1;
   localparam logic [2:0] SMSP_ROLE_DIV64 = 3'h2;
   localparam logic [2:0] SMSP_ROLE_LIRC = 3'h3;
   localparam logic [2:0] SMSP_ROLE_SLAVE = 3'h5;
   localparam logic [2:0] SMSP_ROLE_TWO_WIRE = 3'h6;

   // Half periods of the serial clock in system clocks
   localparam logic [4:0] SMSP_HALF_DIV4 = 5'h02;
   localparam logic [4:0] SMSP_HALF_DIV16 = 5'h08;
   localparam logic [4:0] SMSP_HALF_DIV64 = 5'h20;

   localparam logic [2:0] SMSP_LAST_BIT = 3'h7;

   localparam logic [1:0] SMSP_HTRANS_NONSEQ = 2'h2;

   typedef enum logic [2:0] {
      SMSP_ST_IDLE = 3'b001,
      SMSP_ST_MASTER = 3'b010,
      SMSP_ST_SLAVE = 3'b100
   } smsp_state_type;

   typedef struct packed {
      logic sck;
      logic sdi;
      logic scs_b;
   } smsp_pin_in_type;

   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic sdo;
      logic sdo_oe;
      logic select_pin_func;
      logic port_pins_func;
   } smsp_pin_out_type;

   function automatic logic smsp_is_master(input logic [2:0] role);
      smsp_is_master = (role == SMSP_ROLE_DIV4) || (role == SMSP_ROLE_DIV16) ||
         (role == SMSP_ROLE_DIV64) || (role == SMSP_ROLE_LIRC);
   endfunction

   function automatic logic smsp_out_bit(input logic [7:0] d, input logic msb_first);
      smsp_out_bit = msb_first ? d[7] : d[0];
   endfunction

   function automatic logic [7:0] smsp_shift(input logic [7:0] d, input logic b, input logic msb_first);
      smsp_shift = msb_first ? {d[6:0], b} : {b, d[7:1]};
   endfunction

endpackage

//--- core/smsp_bit_clock.sv
`timescale 1ns/1ps
`default_nettype none
module smsp_bit_clock (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [2:0] role,
   input wire logic lirc_tick,
   output logic tick
);
   import smsp_pkg::*;

   logic [4:0] count;
   logic [4:0] next_count;
   logic [4:0] half;

   always_comb begin
      half = SMSP_HALF_DIV4;
      if (role == SMSP_ROLE_DIV16) begin
         half = SMSP_HALF_DIV16;
      end else if (role == SMSP_ROLE_DIV64) begin
         half = SMSP_HALF_DIV64;
      end
      tick = 1'b0;
      next_count = 5'h00;
      if (run) begin
         if (role == SMSP_ROLE_LIRC) begin
            // Each oscillator tick is one half period
            tick = lirc_tick;
         end else if (count == half - 5'h01) begin
            tick = 1'b1;
         end else begin
            next_count = count + 5'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 5'h00;
      end else begin
         count <= next_count;
      end
   end

endmodule
`default_nettype wire

//--- core/smsp_port.sv
// Overview of operation
// - Polarity bit 1 idles clock low, 0 idles it high.
// - Capture edge follows polarity and capture-edge bit combination.
// - Shift-order bit 1 sends MSB first, 0 sends LSB first.
// - Select-pin enable bit hands select pin to port or GPIO.
// - Data write during transfer is dropped and sets collision flag.
// - Collision flag stays set until software writes it zero.
// - Completion flag set at byte end, cleared only by software.
// - Master data write starts a full-duplex byte transfer at once.
// - Slave shifts data register out and input bits in on clocks.
// - Slave with select pin disabled stays active, ignores select line.
// - Port keeps working during processor idle power mode.
// - Two upper control bits store and return written values.
// - Role field picks master rates, slave or two-wire mode; the two-wire code only releases the pins here.
// - Disabled port releases pins, stays idle, keeps control settings.
// - One shared byte register holds sent and received data.
`timescale 1ns/1ps
`default_nettype none
module smsp_port (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic lirc_tick,
   input wire smsp_pkg::smsp_pin_in_type pin_in,
   output smsp_pkg::smsp_pin_out_type pin_out,
   output logic irq
);
   import smsp_pkg::*;

   logic dp_valid, next_dp_valid;
   logic dp_write, next_dp_write;
   logic [7:0] dp_addr, next_dp_addr;
   logic [7:0] mode_ctl, next_mode_ctl;
   logic [7:0] sdata, next_sdata;
   logic [7:0] port_ctl, next_port_ctl;
   logic [1:0] irq_status, next_irq_status;
   logic [1:0] irq_mask, next_irq_mask;
   smsp_state_type state, next_state;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic sck_q, next_sck_q;
   logic sck_prev, next_sck_prev;
   logic rx_hold, next_rx_hold;
   logic sdo_q, next_sdo_q;

   logic enabled, master_role, slave_role, slave_active;
   logic idle_level, capture_lead, msb_first;
   logic tick, lead_ev, trail_ev, done_ev, collide_ev, start_ev;
   logic wr_mode, wr_data, wr_port, wr_stat, wr_mask;
   logic [7:0] wbyte;
   logic [2:0] role;

   assign role = mode_ctl[SMSP_ROLE_MSB:SMSP_ROLE_LSB];
   // Disabled module leaves the role decode but releases everything
   assign enabled = mode_ctl[SMSP_ENABLE_BIT];
   assign master_role = enabled && smsp_is_master(role);
   assign slave_role = enabled && (role == SMSP_ROLE_SLAVE);
   // select ignored when its pin is not enabled
   assign slave_active = slave_role && (!port_ctl[SMSP_SEL_EN_BIT] || !pin_in.scs_b);
   assign idle_level = !port_ctl[SMSP_POL_BIT];
   // edge bit 1 captures on the edge leaving idle
   assign capture_lead = port_ctl[SMSP_EDGE_BIT];
   assign msb_first = port_ctl[SMSP_ORDER_BIT];

   smsp_bit_clock u_bit_clock (
      .clk(clk),
      .rst_b(rst_b),
      .run(state == SMSP_ST_MASTER),
      .role(role),
      .lirc_tick(lirc_tick),
      .tick(tick)
   );

   assign wbyte = hwdata[7:0];
   assign wr_mode = dp_valid && dp_write && (dp_addr == SMSP_OFS_MODE_CTL);
   assign wr_data = dp_valid && dp_write && (dp_addr == SMSP_OFS_DATA);
   assign wr_port = dp_valid && dp_write && (dp_addr == SMSP_OFS_PORT_CTL);
   assign wr_stat = dp_valid && dp_write && (dp_addr == SMSP_OFS_IRQ_STATUS);
   assign wr_mask = dp_valid && dp_write && (dp_addr == SMSP_OFS_IRQ_MASK);

   // Edges of the serial clock, either our own or the master's
   always_comb begin
      lead_ev = 1'b0;
      trail_ev = 1'b0;
      if (state == SMSP_ST_MASTER) begin
         lead_ev = tick && (sck_q == idle_level);
         trail_ev = tick && (sck_q != idle_level);
      end else if (slave_active && (pin_in.sck != sck_prev)) begin
         lead_ev = (pin_in.sck != idle_level);
         trail_ev = (pin_in.sck == idle_level) && (state == SMSP_ST_SLAVE);
      end
   end

   // eighth trailing edge ends the byte
   assign done_ev = trail_ev && (bit_cnt == SMSP_LAST_BIT);
   assign collide_ev = wr_data && (state != SMSP_ST_IDLE);
   assign start_ev = wr_data && (state == SMSP_ST_IDLE) && master_role;

   // Bus address phase capture
   always_comb begin
      next_dp_valid = dp_valid;
      next_dp_write = dp_write;
      next_dp_addr = dp_addr;
      if (hready) begin
         next_dp_valid = hsel && (htrans == SMSP_HTRANS_NONSEQ);
         next_dp_write = hwrite;
         next_dp_addr = haddr[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_valid <= next_dp_valid;
         dp_write <= next_dp_write;
         dp_addr <= next_dp_addr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_comb begin
      hrdata = 32'h00000000;
      if (dp_valid && !dp_write) begin
         unique case (dp_addr)
            SMSP_OFS_MODE_CTL: hrdata = {24'h000000, mode_ctl};
            SMSP_OFS_DATA: hrdata = {24'h000000, sdata};
            SMSP_OFS_PORT_CTL: hrdata = {24'h000000, port_ctl};
            SMSP_OFS_IRQ_STATUS: hrdata = {30'h00000000, irq_status};
            SMSP_OFS_IRQ_MASK: hrdata = {30'h00000000, irq_mask};
            default: hrdata = 32'h00000000;
         endcase
      end
   end

   // Registers and the shift engine
   always_comb begin
      next_mode_ctl = mode_ctl;
      next_port_ctl = port_ctl;
      next_sdata = sdata;
      next_irq_status = irq_status;
      next_irq_mask = irq_mask;
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_sck_q = sck_q;
      next_rx_hold = rx_hold;
      next_sdo_q = sdo_q;
      next_sck_prev = pin_in.sck;

      // settings survive disable, a mode write replaces bits 7 to 1
      if (wr_mode) begin
         next_mode_ctl = wbyte & SMSP_MODE_CTL_RW;
      end
      if (wr_port) begin
         next_port_ctl = wbyte;
      end
      // collision flag cleared only by software, set wins
      if (collide_ev) begin
         next_port_ctl[SMSP_WRITE_COLLISION_FLAG_BIT] = 1'b1;
      end
      // completion flag set by hardware, set wins over clear
      if (done_ev) begin
         next_port_ctl[SMSP_TRF_BIT] = 1'b1;
      end

      // Sticky copies for the interrupt; set beats a write-one clear
      if (wr_stat) begin
         next_irq_status = irq_status & ~wbyte[1:0];
      end
      if (done_ev) begin
         next_irq_status[SMSP_IRQ_DONE_BIT] = 1'b1;
      end
      if (collide_ev) begin
         next_irq_status[SMSP_IRQ_WRITE_COLLISION_FLAG_BIT] = 1'b1;
      end
      if (wr_mask) begin
         next_irq_mask = wbyte[1:0];
      end

      // the one data register takes both software and shift
      if (wr_data && (state == SMSP_ST_IDLE)) begin
         next_sdata = wbyte;
      end

      // sample input on the capture edge
      if ((lead_ev && capture_lead) || (trail_ev && !capture_lead)) begin
         next_rx_hold = pin_in.sdi;
      end

      unique case (state)
         SMSP_ST_IDLE: begin
            next_bit_cnt = 3'h0;
            // idle level held while no byte runs
            next_sck_q = idle_level;
            if (start_ev) begin
               next_state = SMSP_ST_MASTER;
            end else if (lead_ev) begin
               // slave waits for the master's first edge
               next_state = SMSP_ST_SLAVE;
            end
         end
         SMSP_ST_MASTER: begin
            if (tick) begin
               next_sck_q = !sck_q;
            end
            if (!master_role) begin
               // Abort leaves the clock at idle and no flag raised
               next_state = SMSP_ST_IDLE;
               next_sck_q = idle_level;
            end else if (done_ev) begin
               next_state = SMSP_ST_IDLE;
            end
         end
         SMSP_ST_SLAVE: begin
            if (!slave_active || done_ev) begin
               next_state = SMSP_ST_IDLE;
            end
         end
      endcase

      // shift on every trailing edge, master or slave
      if (trail_ev && (state != SMSP_ST_IDLE)) begin
         next_sdata = smsp_shift(sdata, capture_lead ? rx_hold : pin_in.sdi, msb_first);
         next_bit_cnt = bit_cnt + 3'h1;
      end
      if (state == SMSP_ST_SLAVE && !slave_active) begin
         next_bit_cnt = 3'h0;
      end

      // Output bit stands before the capture edge it is read on
      if (capture_lead) begin
         next_sdo_q = smsp_out_bit(next_sdata, msb_first);
      end else if (lead_ev) begin
         next_sdo_q = smsp_out_bit(sdata, msb_first);
      end
   end

   // no power-mode gating, the engine runs on every edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ctl <= SMSP_RST_MODE_CTL;
         port_ctl <= SMSP_RST_PORT_CTL;
         sdata <= SMSP_RST_DATA;
         irq_status <= SMSP_RST_IRQ;
         irq_mask <= SMSP_RST_IRQ;
         state <= SMSP_ST_IDLE;
         bit_cnt <= 3'h0;
         sck_q <= 1'b1;
         // Idle level of the pin after reset, so no false edge follows
         sck_prev <= 1'b1;
         rx_hold <= 1'b0;
         sdo_q <= 1'b0;
      end else begin
         mode_ctl <= next_mode_ctl;
         port_ctl <= next_port_ctl;
         sdata <= next_sdata;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         sck_q <= next_sck_q;
         sck_prev <= next_sck_prev;
         rx_hold <= next_rx_hold;
         sdo_q <= next_sdo_q;
      end
   end

   // pins released to general I/O when disabled or two-wire
   always_comb begin
      pin_out.port_pins_func = master_role || slave_role;
      pin_out.select_pin_func = slave_role && port_ctl[SMSP_SEL_EN_BIT];
      pin_out.sck = sck_q;
      pin_out.sck_oe = master_role;
      pin_out.sdo = sdo_q;
      pin_out.sdo_oe = master_role || slave_active;
   end

   assign irq = |(irq_status & irq_mask);

endmodule
`default_nettype wire

//--- verification/smsp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module smsp_port_mon (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire smsp_pkg::smsp_pin_out_type pin_out,
   input wire logic irq
);
   import smsp_pkg::*;
   logic rd_ph;
   logic next_rd_ph;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   always_comb begin
      next_rd_ph = hsel && hready && htrans == SMSP_HTRANS_NONSEQ && !hwrite;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_ph <= 1'b0;
      end else begin
         rd_ph <= next_rd_ph;
      end
   end
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_read_quiet: assert property (!rd_ph |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   a_read_upper: assert property (rd_ph |-> hrdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   a_pins_released: assert property (!pin_out.port_pins_func |-> !pin_out.sck_oe && !pin_out.sdo_oe)
      else $error("pins driven while port released");
   a_clock_owner: assert property (pin_out.sck_oe |-> pin_out.port_pins_func)
      else $error("clock driven outside port role");
   a_data_owner: assert property (pin_out.sdo_oe |-> pin_out.port_pins_func)
      else $error("data out driven outside port role");
   a_select_owner: assert property (pin_out.select_pin_func |-> pin_out.port_pins_func && !pin_out.sck_oe)
      else $error("select pin claimed outside slave role");
   a_half_period: assert property (
      pin_out.sck_oe && $past(pin_out.sck_oe) && $changed(pin_out.sck) |=> $stable(pin_out.sck))
      else $error("serial clock half period too short");
   c_master: cover property (pin_out.sck_oe && $changed(pin_out.sck));
   c_slave: cover property (pin_out.sdo_oe && !pin_out.sck_oe);
   c_irq: cover property ($rose(irq));
endmodule
bind smsp_port smsp_port_mon u_mon (.clk(clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_out(pin_out), .irq(irq));
`default_nettype wire

//--- verification/smsp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module smsp_peer (
   input wire logic sck,
   input wire logic sdo,
   input wire logic cap_rise,
   input wire logic msb,
   input wire logic [7:0] tx,
   input wire logic load,
   output logic sdi,
   output logic [7:0] rx
);
   logic [7:0] sh;
   int cnt = 8;
   initial sdi = 1'b0;
   // First bit stands before any edge
   always @(posedge load) begin
      sh = tx;
      cnt = 0;
      sdi = msb ? tx[7] : tx[0];
   end
   always @(sck) begin
      if (cnt < 8 && sck === cap_rise) begin
         rx = msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
         cnt++;
         // Released line must not keep its last value
         if (cnt == 8) begin
            sdi = ~sdi;
         end
      end else if (cnt > 0 && cnt < 8 && sck === !cap_rise) begin
         sh = msb ? sh << 1 : sh >> 1;
         sdi = msb ? sh[7] : sh[0];
      end
   end
endmodule
`default_nettype wire

//--- verification/smsp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module smsp_port_tb;
   import smsp_pkg::*;
   logic clk, rst_b, hsel, hwrite, hready, hresp, lirc_tick, irq;
   logic s_sck, s_sdi, s_scs_b, slv, p_load, p_cap, p_msb, p_sdi;
   logic [1:0] htrans, lt;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] p_tx, p_rx, r, cfg, g;
   logic [7:0] offm [3] = '{8'h00, 8'hc2, 8'h82};
   int miscompares, checked;
   smsp_pin_in_type pin_in;
   smsp_pin_out_type pin_out;
   assign pin_in = {s_sck, slv ? s_sdi : p_sdi, s_scs_b};
   smsp_port uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .lirc_tick(lirc_tick), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
   smsp_peer peer (.sck(pin_out.sck), .sdo(pin_out.sdo), .cap_rise(p_cap), .msb(p_msb), .tx(p_tx),
      .load(p_load), .sdi(p_sdi), .rx(p_rx));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      lt <= lt + 2'h1;
      lirc_tick <= (lt == 2'h3);
   end
   task automatic final_report;
      if (miscompares == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hw;
      int n;
      n = 0;
      @(negedge clk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            miscompares++;
            final_report;
         end
         @(negedge clk);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= SMSP_HTRANS_NONSEQ;
      hw;
      @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      hw;
      r = hrdata[7:0];
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      bus(a, 1'b0, 8'h00);
      chk(nm, r, exp);
   endtask
   task automatic done_wait;
      int n;
      n = 0;
      bus(SMSP_OFS_PORT_CTL, 1'b0, 8'h00);
      while (r[0] !== 1'b1) begin
         n++;
         if (n > 400) begin
            miscompares++;
            final_report;
         end
         bus(SMSP_OFS_PORT_CTL, 1'b0, 8'h00);
      end
   endtask
   // Bench plays master with idle-high clock; ck picks capture on the leading edge
   task automatic sxfer(input logic [7:0] t, input logic ck);
      for (int b = 7; b >= 0; b--) begin
         s_sck <= ck;
         s_sdi <= t[b];
         repeat (3) @(posedge clk);
         @(negedge clk);
         g[b] = pin_out.sdo;
         @(posedge clk);
         s_sck <= !ck;
         repeat (4) @(posedge clk);
      end
      // Last trailing edge, needed when capture is on the leading edge
      s_sck <= 1'b1;
      s_sdi <= ~t[0];
      repeat (4) @(posedge clk);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      final_report;
   end
   initial begin
      {rst_b, hsel, hwrite, htrans, haddr, hwdata, lt, lirc_tick} = '0;
      {s_sdi, slv, p_load, p_tx, miscompares, checked} = '0;
      {s_sck, s_scs_b, p_cap, p_msb} = 4'hf;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(SMSP_OFS_MODE_CTL, 8'he0, "mode reset");
      rd(SMSP_OFS_PORT_CTL, 8'h00, "port reset");
      bus(8'h14, 1'b1, 8'hff);
      rd(8'h14, 8'h00, "unmapped");
      for (int i = 0; i < 4; i++) begin
         cfg = {2'b00, i[0], i[1], ~i[0], 3'b000};
         bus(SMSP_OFS_MODE_CTL, 1'b1, {i[2:0], 5'b00010});
         bus(SMSP_OFS_PORT_CTL, 1'b1, cfg);
         bus(SMSP_OFS_IRQ_MASK, 1'b1, {7'h0, i[0]});
         #1;
         chk("sck idle", pin_out.sck, {7'h0, ~i[0]});
         chk("master drive", {pin_out.sck_oe, pin_out.sdo_oe}, 8'h03);
         p_tx <= 8'h3a - i[7:0];
         p_cap <= ~(i[0] ^ i[1]);
         p_msb <= ~i[0];
         p_load <= 1'b1;
         @(posedge clk);
         p_load <= 1'b0;
         bus(SMSP_OFS_DATA, 1'b1, 8'hc5 + i[7:0]);
         bus(SMSP_OFS_DATA, 1'b1, 8'hff);
         rd(SMSP_OFS_PORT_CTL, cfg | 8'h02, "collision");
         done_wait;
         rd(SMSP_OFS_PORT_CTL, cfg | 8'h03, "sticky flags");
         #1;
         chk("irq masked", irq, {7'h0, i[0]});
         rd(SMSP_OFS_IRQ_STATUS, 8'h03, "irq status");
         bus(SMSP_OFS_IRQ_STATUS, 1'b1, 8'h03);
         #1;
         chk("irq clear", irq, 8'h00);
         bus(SMSP_OFS_PORT_CTL, 1'b1, cfg);
         rd(SMSP_OFS_PORT_CTL, cfg, "flags cleared");
         rd(SMSP_OFS_DATA, 8'h3a - i[7:0], "master rx");
         chk("peer rx", p_rx, 8'hc5 + i[7:0]);
         #1;
         chk("sck end", pin_out.sck, {7'h0, ~i[0]});
      end
      foreach (offm[k]) begin
         bus(SMSP_OFS_MODE_CTL, 1'b1, offm[k]);
         #1;
         chk("pins released", pin_out.port_pins_func, 8'h00);
      end
      rd(SMSP_OFS_PORT_CTL, cfg, "settings kept");
      bus(SMSP_OFS_PORT_CTL, 1'b1, 8'hc0);
      rd(SMSP_OFS_PORT_CTL, 8'hc0, "spare bits");
      bus(SMSP_OFS_MODE_CTL, 1'b1, 8'h1d);
      rd(SMSP_OFS_MODE_CTL, 8'h1c, "mode bits");
      slv <= 1'b1;
      s_scs_b <= 1'b0;
      bus(SMSP_OFS_MODE_CTL, 1'b1, 8'ha2);
      // Second pass: select pin disabled, line left high, capture on leading edge
      for (int j = 0; j < 2; j++) begin
         bus(SMSP_OFS_PORT_CTL, 1'b1, j[0] ? 8'h18 : 8'h0c);
         s_scs_b <= j[0];
         bus(SMSP_OFS_DATA, 1'b1, 8'h5a ^ j[7:0]);
         sxfer(8'hc3 + j[7:0], j[0]);
         chk("slave tx", g, 8'h5a ^ j[7:0]);
         #1;
         chk("select pin", pin_out.select_pin_func, {7'h0, ~j[0]});
         chk("slave drive", {pin_out.sck_oe, pin_out.sdo_oe}, 8'h01);
         done_wait;
         rd(SMSP_OFS_DATA, 8'hc3 + j[7:0], "slave rx");
      end
      final_report;
   end
endmodule
`default_nettype wire
